// *** rtl/arx_pkg.sv ***
// Constants, register layouts and types for the ARINC receiver SPI command block
package arx_pkg;
   // Instruction op codes
   localparam logic [7:0] ARX_OP_WR_DIV = 8'h07;
   localparam logic [7:0] ARX_OP_WR_LBL = 8'h06;
   localparam logic [7:0] ARX_OP_RD_FIFO = 8'h08;
   localparam logic [7:0] ARX_OP_RD_STAT = 8'h0A;
   localparam logic [7:0] ARX_OP_RD_CFG = 8'h0B;
   localparam logic [7:0] ARX_OP_RD_DIV = 8'h0C;
   localparam logic [7:0] ARX_OP_RD_LBL = 8'h0D;
   localparam logic [7:0] ARX_OP_WR_CFG = 8'h10;
   // Data field lengths in bits, and the top label table index
   localparam logic [8:0] ARX_LEN_WORD = 9'h020;
   localparam logic [8:0] ARX_LEN_STAT = 9'h008;
   localparam logic [8:0] ARX_LEN_CFG = 9'h010;
   localparam logic [8:0] ARX_LEN_DIV = 9'h008;
   localparam logic [8:0] ARX_LEN_LBL = 9'h100;
   localparam logic [7:0] ARX_LBL_TOP = 8'hFF;
   // Reset values
   localparam logic [15:0] ARX_CFG_RESET = 16'h0000;
   localparam logic [7:0] ARX_DIV_RESET = 8'h01;
   localparam logic [255:0] ARX_LBL_RESET = 256'h0;
   // Receive store and staging buffer geometry
   localparam int ARX_WORD_W = 32;
   localparam int ARX_STAGE_DEPTH = 4;
   localparam int ARX_RX_DEPTH = 32;
   localparam logic [5:0] ARX_RX_FULL = 6'h20;
   localparam logic [5:0] ARX_RX_HALF = 6'h10;
   // Receive rate dividers applied to the ARINC clock
   localparam logic [6:0] ARX_RATE_HI_DIV = 7'h0A;
   localparam logic [6:0] ARX_RATE_LO_DIV = 7'h50;

   typedef struct packed {
      logic flag_pin_select_bit;
      logic [2:0] unused_14_12;
      logic label_order_select_bit;
      logic [1:0] unused_10_9;
      logic expected_bit9_value;
      logic expected_bit10_value;
      logic sdi_decoder_enable_bit;
      logic receiver_enable_bit;
      logic parity_check_enable_bit;
      logic unused_3;
      logic label_filter_enable_bit;
      logic clock_source_select_bit;
      logic rate_select_bit;
   } arx_cfg_t;

   typedef struct packed {
      logic [1:0] zero_7_6;
      logic [2:0] undef_5_3;
      logic fifo_full_flag;
      logic fifo_half_full_flag;
      logic fifo_empty_flag;
   } arx_status_t;

   typedef enum logic [1:0] {
      ARX_ST_OPCODE = 2'b00,
      ARX_ST_READ = 2'b01,
      ARX_ST_WRITE = 2'b10,
      ARX_ST_IGNORE = 2'b11
   } arx_spi_state_t;
endpackage

// *** rtl/arx_spi_cmd.sv ***
// SPI command decoder, configuration/status registers and receive store of the ARINC receiver
`timescale 1ns/1ns

module arx_stage_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_q[rd_q];
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Ready and valid are registered so both edges of the buffer are honest flops
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
         out_valid_o <= (cnt_d != '0);
      end
   end
endmodule // arx_stage_fifo

module arx_spi_cmd
   import arx_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_si_i,
   output logic spi_so_o,
   input wire logic master_clear_i,
   input wire logic aclk_i,
   input wire logic [31:0] rx_word_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   output logic fifo_flag_output,
   output logic rate_tick_o,
   output logic [15:0] cfg_o
);
   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   function automatic logic div_valid(input logic [7:0] d);
      return (d == 8'h01) || (d == 8'h02) || (d == 8'h04) || (d == 8'h08) || (d == 8'h0A);
   endfunction

   // Pin synchronisers: stage one feeds stage two only
   logic [4:0] pin_a_q;
   logic [4:0] pin_b_q;
   logic sck_d_q;
   logic aclk_d_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_a_q <= 5'h02;
         pin_b_q <= 5'h02;
         sck_d_q <= 1'b0;
         aclk_d_q <= 1'b0;
      end else begin
         pin_a_q <= {aclk_i, master_clear_i, spi_si_i, spi_cs_n_i, spi_sck_i};
         pin_b_q <= pin_a_q;
         sck_d_q <= pin_b_q[0];
         aclk_d_q <= pin_b_q[4];
      end
   end
   logic sck_s, cs_n_s, si_s, mclr_s, aclk_s;
   assign {aclk_s, mclr_s, si_s, cs_n_s, sck_s} = pin_b_q;
   logic sck_rise, sck_fall, aclk_rise;
   assign sck_rise = sck_s & ~sck_d_q & ~cs_n_s;
   assign sck_fall = ~sck_s & sck_d_q & ~cs_n_s;
   assign aclk_rise = aclk_s & ~aclk_d_q;

   arx_cfg_t cfg_q;
   logic [7:0] div_q;
   logic [255:0] lbl_q;
   arx_status_t stat;

   // Timing clock: optional programmed divide, then rate divide
   logic [7:0] adiv_cnt_q;
   logic [6:0] rate_cnt_q;
   logic arinc_tick;
   logic [6:0] rate_len;
   assign arinc_tick = cfg_q.clock_source_select_bit ?
      (aclk_rise & div_valid(div_q) & (adiv_cnt_q == div_q - 8'h01)) : aclk_rise;
   assign rate_len = cfg_q.rate_select_bit ? ARX_RATE_LO_DIV : ARX_RATE_HI_DIV;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         adiv_cnt_q <= 8'h00;
         rate_cnt_q <= 7'h00;
         rate_tick_o <= 1'b0;
      end else begin
         if (aclk_rise) begin
            adiv_cnt_q <= (adiv_cnt_q >= div_q - 8'h01) ? 8'h00 : adiv_cnt_q + 8'h01;
         end
         rate_tick_o <= 1'b0;
         if (arinc_tick) begin
            if (rate_cnt_q >= rate_len - 7'h01) begin
               rate_cnt_q <= 7'h00;
               rate_tick_o <= 1'b1;
            end else begin
               rate_cnt_q <= rate_cnt_q + 7'h01;
            end
         end
      end
   end

   // Staging buffer between the receiver and the store
   logic [31:0] stg_data;
   logic stg_valid;
   logic stg_ready;
   arx_stage_fifo #(.WIDTH(ARX_WORD_W), .DEPTH(ARX_STAGE_DEPTH)) u_stage (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_data_i(rx_word_i),
      .in_valid_i(rx_valid_i),
      .in_ready_o(rx_ready_o),
      .out_data_o(stg_data),
      .out_valid_o(stg_valid),
      .out_ready_i(stg_ready)
   );

   // Word acceptance; label filter uses the label byte as it appears on SPI
   logic [31:0] rx_fix;
   logic [7:0] rx_label;
   logic accept;
   assign rx_fix = {cfg_q.parity_check_enable_bit ? ~^stg_data : stg_data[31], stg_data[30:0]};
   assign rx_label = cfg_q.label_order_select_bit ? stg_data[7:0] : rev8(stg_data[7:0]);
   assign accept = cfg_q.receiver_enable_bit
      & (~cfg_q.label_filter_enable_bit | lbl_q[rx_label])
      & (~cfg_q.sdi_decoder_enable_bit
         | ({stg_data[9], stg_data[8]} == {cfg_q.expected_bit10_value, cfg_q.expected_bit9_value}));

   // SPI command engine
   arx_spi_state_t st_q;
   logic [7:0] op_q;
   logic [8:0] cnt_q;
   logic [8:0] len_q;
   logic [31:0] rd_sr_q;
   logic [15:0] wr_sr_q;
   logic [7:0] op_full;
   logic op_done;
   logic pop_now;
   assign op_full = {op_q[6:0], si_s};
   assign op_done = sck_rise & (st_q == ARX_ST_OPCODE) & (cnt_q == 9'h007);
   assign pop_now = op_done & (op_full == ARX_OP_RD_FIFO);
   // Draining stalls for the cycle a word is popped so the store sees one change at a time
   assign stg_ready = ~pop_now;

   // Receive store
   logic [31:0] store_q [ARX_RX_DEPTH];
   logic [4:0] wp_q;
   logic [4:0] rp_q;
   logic [5:0] cnt_rx_q;
   logic store_wr;
   logic store_pop;
   assign store_wr = stg_valid & stg_ready & accept;
   assign store_pop = pop_now & (cnt_rx_q != 6'h00);

   always_ff @(posedge clk_i) begin
      if (store_wr) begin
         // When full the newest word overwrites the last location
         store_q[(cnt_rx_q == ARX_RX_FULL) ? wp_q - 5'h01 : wp_q] <= rx_fix;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || mclr_s) begin
         wp_q <= 5'h00;
         rp_q <= 5'h00;
         cnt_rx_q <= 6'h00;
      end else begin
         if (store_wr && cnt_rx_q != ARX_RX_FULL) begin
            wp_q <= wp_q + 5'h01;
         end
         if (store_pop) begin
            rp_q <= rp_q + 5'h01;
         end
         if (store_wr && cnt_rx_q != ARX_RX_FULL && !store_pop) begin
            cnt_rx_q <= cnt_rx_q + 6'h01;
         end else if (store_pop && !(store_wr && cnt_rx_q != ARX_RX_FULL)) begin
            cnt_rx_q <= cnt_rx_q - 6'h01;
         end
      end
   end

   assign stat.zero_7_6 = 2'h0;
   assign stat.undef_5_3 = 3'h0;
   assign stat.fifo_empty_flag = (cnt_rx_q == 6'h00);
   assign stat.fifo_half_full_flag = (cnt_rx_q >= ARX_RX_HALF);
   assign stat.fifo_full_flag = (cnt_rx_q == ARX_RX_FULL);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fifo_flag_output <= 1'b1;
      end else begin
         fifo_flag_output <= cfg_q.flag_pin_select_bit ? stat.fifo_full_flag : stat.fifo_empty_flag;
      end
   end

   // Read word in SPI bit order
   logic [31:0] head_spi;
   assign head_spi = {store_q[rp_q][31:8],
      cfg_q.label_order_select_bit ? store_q[rp_q][7:0] : rev8(store_q[rp_q][7:0])};

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || cs_n_s) begin
         st_q <= ARX_ST_OPCODE;
         op_q <= 8'h00;
         cnt_q <= 9'h000;
         len_q <= 9'h000;
         rd_sr_q <= 32'h0000_0000;
         wr_sr_q <= 16'h0000;
         spi_so_o <= 1'b0;
      end else begin
         case (st_q)
            ARX_ST_OPCODE: begin
               if (sck_rise) begin
                  op_q <= op_full;
                  cnt_q <= cnt_q + 9'h001;
                  if (op_done) begin
                     cnt_q <= 9'h000;
                     st_q <= ARX_ST_READ;
                     case (op_full)
                        ARX_OP_RD_FIFO: begin
                           len_q <= ARX_LEN_WORD;
                           rd_sr_q <= (cnt_rx_q != 6'h00) ? head_spi : 32'h0000_0000;
                        end
                        ARX_OP_RD_STAT: begin
                           len_q <= ARX_LEN_STAT;
                           rd_sr_q <= {stat, 24'h00_0000};
                        end
                        ARX_OP_RD_CFG: begin
                           len_q <= ARX_LEN_CFG;
                           rd_sr_q <= {cfg_q, 16'h0000};
                        end
                        ARX_OP_RD_DIV: begin
                           len_q <= ARX_LEN_DIV;
                           rd_sr_q <= {div_q, 24'h00_0000};
                        end
                        ARX_OP_RD_LBL: begin
                           len_q <= ARX_LEN_LBL;
                        end
                        ARX_OP_WR_CFG: begin
                           len_q <= ARX_LEN_CFG;
                           st_q <= ARX_ST_WRITE;
                        end
                        ARX_OP_WR_DIV: begin
                           len_q <= ARX_LEN_DIV;
                           st_q <= ARX_ST_WRITE;
                        end
                        ARX_OP_WR_LBL: begin
                           len_q <= ARX_LEN_LBL;
                           st_q <= ARX_ST_WRITE;
                        end
                        default: begin
                           st_q <= ARX_ST_IGNORE;
                        end
                     endcase
                  end
               end
            end
            ARX_ST_READ: begin
               if (sck_fall) begin
                  // Label table has no shift copy; bits are indexed straight from FF down
                  spi_so_o <= (op_q == ARX_OP_RD_LBL) ? lbl_q[ARX_LBL_TOP - cnt_q[7:0]]
                                                      : rd_sr_q[5'(31 - cnt_q[4:0])];
                  cnt_q <= cnt_q + 9'h001;
                  if (cnt_q == len_q - 9'h001) begin
                     st_q <= ARX_ST_IGNORE;
                  end
               end
            end
            ARX_ST_WRITE: begin
               if (sck_rise) begin
                  wr_sr_q <= {wr_sr_q[14:0], si_s};
                  cnt_q <= cnt_q + 9'h001;
                  if (cnt_q == len_q - 9'h001) begin
                     st_q <= ARX_ST_IGNORE;
                  end
               end
            end
            ARX_ST_IGNORE: begin
               // Last read bit stands until deselect so the host can sample it after its final fall
               st_q <= ARX_ST_IGNORE;
            end
            default: begin
               st_q <= ARX_ST_IGNORE;
            end
         endcase
      end
   end

   logic wr_last;
   assign wr_last = (st_q == ARX_ST_WRITE) & sck_rise & ~cs_n_s & (cnt_q == len_q - 9'h001);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cfg_q <= ARX_CFG_RESET;
         div_q <= ARX_DIV_RESET;
         cfg_o <= ARX_CFG_RESET;
      end else begin
         if (wr_last && op_q == ARX_OP_WR_CFG) begin
            cfg_q <= {wr_sr_q[14:0], si_s};
         end
         if (wr_last && op_q == ARX_OP_WR_DIV) begin
            div_q <= {wr_sr_q[6:0], si_s};
         end
         cfg_o <= cfg_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lbl_q <= ARX_LBL_RESET;
      end else if (st_q == ARX_ST_WRITE && sck_rise && !cs_n_s && op_q == ARX_OP_WR_LBL) begin
         lbl_q[ARX_LBL_TOP - cnt_q[7:0]] <= si_s;
      end
   end
endmodule // arx_spi_cmd

// *** test/arx_spi_cmd_asserts.sv ***
// Port-level checker for the ARINC receiver SPI command block
`timescale 1ns/1ns
module arx_spi_cmd_asserts
   import arx_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_si_i,
   input wire logic spi_so_o,
   input wire logic master_clear_i,
   input wire logic aclk_i,
   input wire logic [31:0] rx_word_i,
   input wire logic rx_valid_i,
   input wire logic rx_ready_o,
   input wire logic fifo_flag_output,
   input wire logic rate_tick_o,
   input wire logic [15:0] cfg_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_reset;
      disable iff (1'b0) sys_rst_i |=> !spi_so_o && rx_ready_o && fifo_flag_output && !rate_tick_o && cfg_o == 16'h0000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   property p_so_idle;
      spi_cs_n_i [*6] |-> !spi_so_o;
   endproperty
   a_so_idle: assert property (p_so_idle) else $error("serial out driven while deselected");
   property p_so_quiet;
      $fell(spi_cs_n_i) |-> !spi_so_o [*8];
   endproperty
   a_so_quiet: assert property (p_so_quiet) else $error("serial out active during op code");
   property p_tick_gap;
      rate_tick_o |=> !rate_tick_o [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("rate ticks too close");
   property p_cfg_stable;
      spi_cs_n_i [*6] |=> $stable(cfg_o);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("configuration changed while deselected");
   property p_cfg_cs;
      $changed(cfg_o) |-> !spi_cs_n_i;
   endproperty
   a_cfg_cs: assert property (p_cfg_cs) else $error("configuration changed outside an instruction");
   property p_flag_mclr;
      (master_clear_i && !rx_valid_i) [*8] |-> fifo_flag_output == !cfg_o[15];
   endproperty
   a_flag_mclr: assert property (p_flag_mclr) else $error("flag wrong after clear");
   property p_ready_idle;
      !rx_valid_i [*8] |-> rx_ready_o;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("staging not drained when idle");
   c_cfg: cover property ($changed(cfg_o));
   c_tick: cover property (rate_tick_o);
   c_so: cover property (spi_so_o);
endmodule // arx_spi_cmd_asserts

// *** test/arx_host_model.sv ***
// SPI host model for the ARINC receiver command interface
`timescale 1ns/1ns
module arx_host_model (
   input wire logic clk_i,
   output logic spi_sck_o,
   output logic spi_cs_n_o,
   output logic spi_si_o,
   input wire logic spi_so_i
);
   initial begin
      spi_sck_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_si_o = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Op code then the low n bits of wdata, MSB first; n bits read back into rdata
   task automatic xfer(input logic [7:0] op, input int n, input logic [255:0] wdata, output logic [255:0] rdata);
      logic [263:0] sh;
      rdata = '0;
      sh = {op, wdata << (256 - n)};
      spi_cs_n_o <= 1'b0;
      wait_clk(6);
      for (int i = 0; i < n + 8; i++) begin
         spi_si_o <= sh[263];
         sh = sh << 1;
         wait_clk(6);
         if (i >= 8) rdata = {rdata[254:0], spi_so_i};
         spi_sck_o <= 1'b1;
         wait_clk(6);
         spi_sck_o <= 1'b0;
      end
      wait_clk(6);
      spi_cs_n_o <= 1'b1;
      // Released line falls to its pull-down level
      spi_si_o <= 1'b0;
      wait_clk(8);
   endtask
endmodule // arx_host_model

// *** test/testbench.sv ***
// Self-checking testbench for the ARINC receiver SPI command block
`timescale 1ns/1ns
module testbench;
   import arx_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i;
   logic master_clear_i;
   logic [31:0] rx_word_i;
   logic rx_valid_i;
   logic [1:0] acnt_q = 2'h0;
   wire logic aclk_i;
   wire logic spi_sck_i, spi_cs_n_i, spi_si_i, spi_so_o, rx_ready_o, fifo_flag_output, rate_tick_o;
   wire logic [15:0] cfg_o;
   logic [255:0] rd;
   int n_fail = 0;
   int samples_checked = 0;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) acnt_q <= acnt_q + 2'h1;
   assign aclk_i = acnt_q[1];
   arx_spi_cmd u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sck_i(spi_sck_i), .spi_cs_n_i(spi_cs_n_i),
      .spi_si_i(spi_si_i), .spi_so_o(spi_so_o), .master_clear_i(master_clear_i), .aclk_i(aclk_i),
      .rx_word_i(rx_word_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
      .fifo_flag_output(fifo_flag_output), .rate_tick_o(rate_tick_o), .cfg_o(cfg_o));
   arx_host_model u_host (.clk_i(clk_i), .spi_sck_o(spi_sck_i), .spi_cs_n_o(spi_cs_n_i), .spi_si_o(spi_si_i),
      .spi_so_i(spi_so_o));
   task automatic close_out();
      $display("Checks made: %0d, mismatches: %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   function automatic logic [31:0] spi_map(input logic [31:0] w, input logic keep, input logic par);
      logic [31:0] r;
      r = w;
      if (par) r[31] = ~^w;
      if (!keep) for (int i = 0; i < 8; i++) r[i] = w[7 - i];
      return r;
   endfunction
   // Word is taken at the rising edge where ready is seen high
   task automatic push(input logic [31:0] w);
      int k;
      k = 0;
      rx_word_i <= w;
      rx_valid_i <= 1'b1;
      forever begin
         @(negedge clk_i);
         if (rx_ready_o === 1'b1) break;
         k++;
         if (k > 100) begin
            check(1'b0, 1'b1, "ready timeout");
            close_out();
         end
      end
      @(posedge clk_i);
   endtask
   task automatic rx_idle();
      rx_valid_i <= 1'b0;
      u_host.wait_clk(10);
   endtask
   task automatic rd_op(input logic [7:0] op, input int n);
      u_host.xfer(op, n, '0, rd);
   endtask
   task automatic wr_cfg(input logic [15:0] v);
      u_host.xfer(ARX_OP_WR_CFG, 16, v, rd);
   endtask
   task automatic t_defaults();
      rd_op(ARX_OP_RD_CFG, 16);
      check(rd[15:0], ARX_CFG_RESET, "cfg reset");
      rd_op(ARX_OP_RD_STAT, 8);
      check(rd[7:0], 8'h01, "status reset");
      check(fifo_flag_output, 1'b1, "flag reset");
      rd_op(ARX_OP_RD_DIV, 8);
      check(rd[7:0], ARX_DIV_RESET, "div reset");
      u_host.xfer(ARX_OP_WR_DIV, 8, 8'h04, rd);
      rd_op(ARX_OP_RD_DIV, 8);
      check(rd[7:0], 8'h04, "div readback");
      // Receiver still disabled, so the word must vanish
      push(32'h1234_5678);
      rx_idle();
      rd_op(ARX_OP_RD_STAT, 8);
      check(rd[7:0], 8'h01, "disabled receiver");
   endtask
   task automatic t_cfg();
      logic [7:0] nops [4];
      nops = '{8'h00, 8'h09, 8'h0E, 8'h0F};
      wr_cfg(16'hA5C3);
      rd_op(ARX_OP_RD_CFG, 16);
      check(rd[15:0], 16'hA5C3, "cfg readback");
      check(cfg_o, 16'hA5C3, "cfg port");
      foreach (nops[i]) begin
         u_host.xfer(nops[i], 16, 16'hFFFF, rd);
         check(rd[15:0], 16'h0000, "ignored op data");
      end
      check(cfg_o, 16'hA5C3, "cfg after ignored ops");
   endtask
   task automatic t_word();
      logic [15:0] c [4];
      logic [31:0] w [4];
      c = '{16'h0020, 16'h0820, 16'h0830, 16'h0830};
      w = '{32'h8B2D_41C6, 32'h0000_00F1, 32'h7000_0003, 32'h0000_0003};
      foreach (c[m]) begin
         wr_cfg(c[m]);
         push(w[m]);
         rx_idle();
         rd_op(ARX_OP_RD_FIFO, 32);
         check(rd[31:0], spi_map(w[m], c[m][11], c[m][4]), "word map");
         rd_op(ARX_OP_RD_STAT, 8);
         check(rd[7:0], 8'h01, "empty after read");
         rd_op(ARX_OP_RD_FIFO, 32);
         check(rd[31:0], 32'h0, "empty read");
      end
   endtask
   task automatic t_filter();
      logic [255:0] tbl;
      tbl = 256'h1 << 8'h3C;
      u_host.xfer(ARX_OP_WR_LBL, 256, tbl, rd);
      rd_op(ARX_OP_RD_LBL, 256);
      check(rd, tbl, "label table");
      wr_cfg(16'h08E4);
      push(32'h0000_023C);
      push(32'h0000_023D);
      push(32'h0000_003C);
      push(32'h0000_033C);
      rx_idle();
      rd_op(ARX_OP_RD_FIFO, 32);
      check(rd[31:0], spi_map(32'h0000_023C, 1'b1, 1'b0), "filtered word");
      rd_op(ARX_OP_RD_FIFO, 32);
      check(rd[31:0], 32'h0, "filtered rest");
   endtask
   task automatic t_fill();
      wr_cfg(16'h8820);
      for (int k = 0; k < 16; k++) push(32'h100 + k);
      rx_idle();
      rd_op(ARX_OP_RD_STAT, 8);
      check(rd[7:0], 8'h02, "half full");
      check(fifo_flag_output, 1'b0, "flag not full");
      for (int k = 16; k < 32; k++) push(32'h100 + k);
      rx_idle();
      rd_op(ARX_OP_RD_STAT, 8);
      check(rd[7:0], 8'h06, "full");
      check(fifo_flag_output, 1'b1, "flag full");
      // Host unloads promptly once full
      rd_op(ARX_OP_RD_FIFO, 32);
      check(rd[31:0], 32'h100, "oldest word");
      rd_op(ARX_OP_RD_STAT, 8);
      check(rd[7:0], 8'h02, "after one pop");
      master_clear_i <= 1'b1;
      u_host.wait_clk(10);
      master_clear_i <= 1'b0;
      u_host.wait_clk(6);
      rd_op(ARX_OP_RD_STAT, 8);
      check(rd[7:0], 8'h01, "master clear");
   endtask
   task automatic count_ticks(input int exp);
      int c;
      c = 0;
      repeat (3200) begin
         @(posedge clk_i);
         if (rate_tick_o === 1'b1) c++;
      end
      check(c >= exp - 1 && c <= exp + 1, 1'b1, "tick count");
   endtask
   task automatic t_rate();
      wr_cfg(16'h0000);
      count_ticks(80);
      wr_cfg(16'h0001);
      count_ticks(10);
      wr_cfg(16'h0002);
      count_ticks(20);
   endtask
   initial begin
      sys_rst_i = 1'b1;
      master_clear_i = 1'b0;
      rx_word_i = 32'h0;
      rx_valid_i = 1'b0;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      u_host.wait_clk(4);
      t_defaults();
      t_cfg();
      t_word();
      t_filter();
      t_fill();
      t_rate();
      close_out();
   end
endmodule // testbench
bind arx_spi_cmd arx_spi_cmd_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sck_i(spi_sck_i),
   .spi_cs_n_i(spi_cs_n_i), .spi_si_i(spi_si_i), .spi_so_o(spi_so_o), .master_clear_i(master_clear_i),
   .aclk_i(aclk_i), .rx_word_i(rx_word_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
   .fifo_flag_output(fifo_flag_output), .rate_tick_o(rate_tick_o), .cfg_o(cfg_o));
